// ### sram_host_consts.svh
// constants for the asynchronous static memory host controller
// assumes a 50 MHz core clock; times are in ns and converted to cycles here
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH

`define CLK_PERIOD_NS 20
`define ADDR_WIDTH 15
`define DATA_WIDTH 16
`define MEM_WORDS 32768
// read cycle time, address to data valid
`define T_RC_NS 15
`define T_AA_NS 15
// write pulse width, data setup, strobe low to high impedance
`define T_PWE_NS 10
`define T_SD_NS 8
`define T_HZWE_NS 4
// release from read drive: output drive high to high impedance
`define T_HZOE_NS 7
// least times round up to whole cycles, never below one
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define READ_CYC `CYC_UP(`T_AA_NS)
`define WRITE_CYC `CYC_UP(`T_HZWE_NS + `T_SD_NS)
`define TURN_CYC `CYC_UP(`T_HZOE_NS)

`endif

// ### sram_host_pkg.sv
// types for the asynchronous static memory host controller
// assumes the constants header is compiled alongside
package sram_host_pkg;
  typedef enum logic [2:0] {
    IDLE,
    SETUP,
    READ,
    WRITE,
    HOLD,
    TURN
  } hostState_t;
endpackage : sram_host_pkg

// ### sram_host.sv
// host controller driving a 32k x 16 asynchronous static memory
// assumes memory pins on the board; one request at a time on the user side
//
// Behaviour
// - write happens only while chip select and write strobe both low.
// - read needs chip select and output drive low, write strobe high.
// - first control returning high ends the write.
// - host holds write data stable around the terminating edge.
// - host never drives data while device drives read data.
// - host presents address no later than chip select falls.
// - strobe pulse at least strobe-to-high-z plus data setup.
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"

module sram_host
  import sram_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [`ADDR_WIDTH-1:0] reqAddr,
  input wire logic [`DATA_WIDTH-1:0] reqWdata,
  input wire logic [1:0] reqByteEn,
  output logic rspValid,
  output logic [`DATA_WIDTH-1:0] rspRdata,
  output logic [`ADDR_WIDTH-1:0] memAddr,
  output logic chipSel_n,
  output logic outDrive_n,
  output logic writeStrobe_n,
  output logic low_byte_lane_n,
  output logic high_byte_lane_n,
  input wire logic [`DATA_WIDTH-1:0] memData_i,
  output logic [`DATA_WIDTH-1:0] memData_o,
  output logic memData_oe
);

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  // data pins come from outside the clock domain
  logic [`DATA_WIDTH-1:0] dataSync1_q, dataSync2_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataSync1_q <= 16'h0000;
      dataSync2_q <= 16'h0000;
    end else begin
      dataSync1_q <= memData_i;
      dataSync2_q <= dataSync1_q;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // two extra cycles on reads cover the synchroniser latency
  localparam logic [3:0] READ_LEN = 4'(`READ_CYC + 2);
  localparam logic [3:0] WRITE_LEN = 4'(`WRITE_CYC);
  localparam logic [3:0] TURN_LEN = 4'(`TURN_CYC);

  hostState_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic write_q, write_d;
  logic [`ADDR_WIDTH-1:0] addr_q, addr_d;
  logic [`DATA_WIDTH-1:0] wdata_q, wdata_d;
  logic [1:0] lanes_n_q, lanes_n_d;
  logic cs_n_q, cs_n_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic drive_q, drive_d;
  logic rspValid_q, rspValid_d;
  logic [`DATA_WIDTH-1:0] rdata_q, rdata_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    write_d = write_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    lanes_n_d = lanes_n_q;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    drive_d = drive_q;
    rspValid_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      IDLE: begin
        // chip select high here puts the memory in standby
        cs_n_d = 1'b1;
        if (reqValid && reqByteEn != 2'b00) begin
          write_d = reqWrite;
          addr_d = reqAddr;
          wdata_d = reqWdata;
          // a lane left high keeps its old byte
          lanes_n_d = ~reqByteEn;
          state_d = SETUP;
        end
      end
      SETUP: begin
        // address already stable one cycle before chip select falls
        cs_n_d = 1'b0;
        if (write_q) begin
          oe_n_d = 1'b1;
          we_n_d = 1'b0;
          drive_d = 1'b1;
          cnt_d = WRITE_LEN;
          state_d = WRITE;
        end else begin
          oe_n_d = 1'b0;
          we_n_d = 1'b1;
          drive_d = 1'b0;
          cnt_d = READ_LEN;
          state_d = READ;
        end
      end
      WRITE: begin
        // one cycle low already covers release plus data setup
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          // strobe alone ends the window; select and data stay
          we_n_d = 1'b1;
          state_d = HOLD;
        end
      end
      HOLD: begin
        // data held one cycle past the terminating edge
        drive_d = 1'b0;
        // select rises a cycle after the strobe, never together
        cs_n_d = 1'b1;
        lanes_n_d = 2'b11;
        rspValid_d = 1'b1;
        state_d = IDLE;
      end
      READ: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          // unselected lanes read as zero; released pins carry junk
          rdata_d = dataSync2_q;
          if (lanes_n_q[0]) rdata_d[7:0] = 8'h00;
          if (lanes_n_q[1]) rdata_d[15:8] = 8'h00;
          rspValid_d = 1'b1;
          oe_n_d = 1'b1;
          cs_n_d = 1'b1;
          lanes_n_d = 2'b11;
          cnt_d = TURN_LEN;
          state_d = TURN;
        end
      end
      TURN: begin
        // wait out the device's release before any write may drive
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) state_d = IDLE;
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      cnt_q <= 4'h0;
      write_q <= 1'b0;
      addr_q <= 15'h0000;
      wdata_q <= 16'h0000;
      lanes_n_q <= 2'h3;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      drive_q <= 1'b0;
      rspValid_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      write_q <= write_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      lanes_n_q <= lanes_n_d;
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      drive_q <= drive_d;
      rspValid_q <= rspValid_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // user side
  // ----------------------------------------
  assign reqReady = (state_q == IDLE);
  assign rspValid = rspValid_q;
  assign rspRdata = rdata_q;

  // ----------------------------------------
  // memory pins
  // ----------------------------------------
  assign memAddr = addr_q;
  assign chipSel_n = cs_n_q;
  assign outDrive_n = oe_n_q;
  assign writeStrobe_n = we_n_q;
  assign low_byte_lane_n = lanes_n_q[0];
  assign high_byte_lane_n = lanes_n_q[1];
  assign memData_o = wdata_q;
  assign memData_oe = drive_q;

endmodule : sram_host
`default_nettype wire

// ### sram_host_assertions.sv
// checker for the memory-side pins of the host controller
// assumes bind onto sram_host; one clock
`timescale 1ns/1ps
`default_nettype none
module sram_host_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [14:0] memAddr,
  input wire logic chipSel_n,
  input wire logic outDrive_n,
  input wire logic writeStrobe_n,
  input wire logic low_byte_lane_n,
  input wire logic high_byte_lane_n,
  input wire logic memData_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence strobePulse;
    !writeStrobe_n ##1 writeStrobe_n;
  endsequence
  a_write_end: assert property (strobePulse |=> rspValid && chipSel_n) else $error("write end");
  a_strobe_one: assert property ($fell(writeStrobe_n) |=> writeStrobe_n) else $error("strobe width");
  a_data_hold: assert property ($rose(writeStrobe_n) |-> memData_oe) else $error("data hold");
  a_write_cs: assert property (!writeStrobe_n |-> !chipSel_n && memData_oe) else $error("write cs");
  a_read_no_we: assert property (!outDrive_n |-> writeStrobe_n && !memData_oe) else $error("read we");
  a_lane_on: assert property (!writeStrobe_n |-> !(low_byte_lane_n && high_byte_lane_n)) else $error("lane");
  a_cs_idle: assert property (chipSel_n |-> outDrive_n && writeStrobe_n) else $error("standby");
  a_addr_first: assert property ($fell(chipSel_n) |-> $stable(memAddr)) else $error("addr late");
endmodule : sram_host_assertions
bind sram_host sram_host_assertions chk (.*);
`default_nettype wire

// ### sram_model.sv
// behavioural 32k x 16 static memory
// assumes host pins split into data out, data in and enable
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input wire logic [14:0] memAddr,
  input wire logic chipSel_n,
  input wire logic outDrive_n,
  input wire logic writeStrobe_n,
  input wire logic low_byte_lane_n,
  input wire logic high_byte_lane_n,
  input wire logic [15:0] memData_o,
  input wire logic memData_oe,
  output logic [15:0] memData_i
);
  logic [15:0] mem [32768];
  logic rd;
  assign rd = !chipSel_n && !outDrive_n && writeStrobe_n;
  // stored at the closing edge, as data is timed to it
  always @(posedge writeStrobe_n) if (!chipSel_n) begin
    if (!low_byte_lane_n) mem[memAddr][7:0] = memData_o[7:0];
    if (!high_byte_lane_n) mem[memAddr][15:8] = memData_o[15:8];
  end
  always_comb begin
    memData_i = ~mem[memAddr]; // released lines never show the right byte
    if (rd && !low_byte_lane_n) memData_i[7:0] = mem[memAddr][7:0];
    if (rd && !high_byte_lane_n) memData_i[15:8] = mem[memAddr][15:8];
    if (memData_oe) memData_i = memData_o;
  end
endmodule : sram_model
`default_nettype wire

// ### test_async_sram_word_byte_access.sv
// self-checking bench for the host controller
// assumes the memory model on the pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, s); end end
module test_async_sram_word_byte_access;
  logic core_clk, reset_n, reqValid, reqReady, reqWrite, rspValid, memData_oe;
  logic chipSel_n, outDrive_n, writeStrobe_n, low_byte_lane_n, high_byte_lane_n;
  logic [14:0] reqAddr, memAddr;
  logic [15:0] reqWdata, rspRdata, memData_i, memData_o;
  logic [1:0] reqByteEn;
  int err_total = 0;
  int n_tests = 0;
  sram_host DUT (.*);
  sram_model mem (.*);
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic req(input logic w, input logic [14:0] a, input logic [15:0] d, input logic [1:0] be);
    int i;
    @(posedge core_clk);
    #1 {reqValid, reqWrite, reqAddr, reqWdata, reqByteEn} = {1'b1, w, a, d, be};
    while (reqReady !== 1'b1) begin @(posedge core_clk); #1; end
    @(posedge core_clk);
    #1 reqValid = 0;
    for (i = 0; i < 20 && rspValid !== 1'b1; i++) begin @(posedge core_clk); #1; end
    `CHK("rspValid", 1'b1, rspValid)
  endtask : req
  task automatic t_word;
    req(1, 15'h7FFF, 16'hA55A, 2'h3);
    req(0, 15'h7FFF, 16'h0000, 2'h3);
    `CHK("word", 16'hA55A, rspRdata)
    $display("t_word done");
  endtask : t_word
  task automatic t_lanes;
    req(1, 15'h0000, 16'h1234, 2'h3);
    req(1, 15'h0000, 16'hABCD, 2'h1);
    req(0, 15'h0000, 16'h0000, 2'h3);
    `CHK("low lane", 16'h12CD, rspRdata)
    req(0, 15'h0000, 16'h0000, 2'h2);
    `CHK("upper only", 16'h1200, rspRdata)
    req(1, 15'h0000, 16'h77EE, 2'h2);
    req(0, 15'h0000, 16'h0000, 2'h1);
    `CHK("lower only", 16'h00CD, rspRdata)
    req(0, 15'h0000, 16'h0000, 2'h3);
    `CHK("high lane", 16'h77CD, rspRdata)
    $display("t_lanes done");
  endtask : t_lanes
  task automatic t_refuse;
    @(posedge core_clk);
    #1 {reqValid, reqWrite, reqByteEn} = {1'b1, 1'b1, 2'h0};
    repeat (6) begin
      @(posedge core_clk);
      #1 `CHK("not taken", 1'b1, reqReady)
      `CHK("no select", 1'b1, chipSel_n)
    end
    reqValid = 0;
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_reset;
    @(posedge core_clk);
    #1 {reqValid, reqWrite, reqAddr, reqByteEn} = {1'b1, 1'b0, 15'h7FFF, 2'h3};
    @(posedge core_clk);
    #1 reqValid = 0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("read select", 1'b0, chipSel_n)
    reset_n = 0;
    #1 `CHK("reset select", 1'b1, chipSel_n)
    `CHK("reset drive", 1'b1, outDrive_n)
    `CHK("reset oe", 1'b0, memData_oe)
    `CHK("reset ready", 1'b1, reqReady)
    `CHK("reset rsp", 1'b0, rspValid)
    `CHK("reset rdata", 16'h0000, rspRdata)
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1;
    req(0, 15'h7FFF, 16'h0000, 2'h3);
    `CHK("after reset", 16'hA55A, rspRdata)
    $display("t_reset done");
  endtask : t_reset
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #100000 err_total++;
    end_of_test;
  end
  initial begin
    {reset_n, reqValid, reqWrite, reqAddr, reqWdata, reqByteEn} = '0;
    repeat (8) @(posedge core_clk);
    #1 reset_n = 1;
    t_word;
    t_lanes;
    t_refuse;
    t_reset;
    end_of_test;
  end
endmodule : test_async_sram_word_byte_access
`default_nettype wire
